// ---- umis_top.sv ----
// Mode options, event flags, interrupt masking and status of the transceiver.
// Assumes the framing core runs on pclk and reports events as one-cycle pulses.
`timescale 1ns/1ps
module umis_top (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial pins
    input wire logic rxd_pin,
    output logic txd_pin,
    output logic sck_out,
    output logic sck_oe,
    input wire logic ri_pin,
    input wire logic dsr_pin,
    input wire logic dcd_pin,
    input wire logic cts_pin,
    // Core line, clock and receive side
    input wire logic core_txd,
    input wire logic core_sck,
    input wire logic sample_tick,
    output logic core_rxd,
    input wire logic rx_char_done,
    input wire logic [8:0] rx_char_data,
    input wire logic parity_evt,
    input wire logic framing_evt,
    input wire logic overrun_evt,
    input wire logic break_evt,
    input wire logic timeout_evt,
    input wire logic nack_evt,
    // Core transmit side
    input wire logic thr_taken,
    input wire logic break_started,
    input wire logic tx_shift_idle,
    output logic thr_valid,
    output logic [8:0] tx_char,
    output logic break_pending,
    output logic nack_req,
    // Framing options for the core
    output logic msb_first,
    output logic [3:0] char_bits,
    output logic rx_enabled,
    output logic tx_enabled,
    // Transfer engine levels
    input wire logic rx_xfer_end,
    input wire logic tx_xfer_end,
    input wire logic tx_buf_empty,
    input wire logic rx_buf_full,
    // Interrupt
    output logic irq
);
    import umis_pkg::*;

    // --------------------------------------------------------------
    // Synchronisers for pin inputs
    // --------------------------------------------------------------
    logic [4:0] pin_meta_q;
    logic [4:0] pin_sync_q;
    logic [3:0] modem_prev_q;
    logic rx_line;
    logic rx_filt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta_q <= 5'h1F;
            pin_sync_q <= 5'h1F;
        end else begin
            pin_meta_q <= {cts_pin, dcd_pin, dsr_pin, ri_pin, rxd_pin};
            pin_sync_q <= pin_meta_q;
        end
    end

    assign rx_line = pin_sync_q[0];

    // --------------------------------------------------------------
    // Register storage
    // --------------------------------------------------------------
    logic [31:0] mode_q;
    logic [31:0] mask_q;
    logic [31:0] status;
    logic rx_en_q;
    logic tx_en_q;
    logic rx_pend_q;
    logic rx_avail_q;
    logic [8:0] rhr_q;
    logic thr_full_q;
    logic [8:0] thr_q;
    logic brk_pend_q;
    logic [13:0] sticky_q;
    logic [3:0] modem_chg_q;
    logic [2:0] iter_cnt_q;
    logic nack_q;
    logic [1:0] loop_mode;
    logic [2:0] max_iter;

    assign loop_mode = mode_q[MD_LOOP_LSB +: 2];
    assign max_iter = mode_q[MD_MAX_ITER_LSB +: 3];

    umis_rx_filter u_filter (
        .pclk(pclk),
        .presetn(presetn),
        .filter_on(mode_q[MD_FILTER]),
        .sample_tick(sample_tick),
        .line_in(rx_line),
        .line_out(rx_filt)
    );

    // --------------------------------------------------------------
    // APB access
    // --------------------------------------------------------------
    logic ready_q;
    logic err_q;
    logic [31:0] rdata_q;
    logic setup;
    logic done;
    logic wr_done;
    logic rd_done;
    logic [31:0] rd_mux;
    logic rd_err;

    assign setup = psel & ~penable & ~ready_q;
    assign done = psel & penable & ready_q;
    assign wr_done = done & pwrite & ~err_q;
    assign rd_done = done & ~pwrite & ~err_q;

    function automatic logic wr_to(input logic [7:0] ofs);
        wr_to = wr_done && (paddr == ofs);
    endfunction

    function automatic logic rd_of(input logic [7:0] ofs);
        rd_of = rd_done && (paddr == ofs);
    endfunction

    always_comb begin
        rd_mux = 32'h00000000;
        rd_err = 1'b0;
        unique case (paddr)
            OFS_CONTROL, OFS_INT_ENABLE, OFS_INT_DISABLE, OFS_TX_HOLD: rd_err = ~pwrite;
            OFS_MODE: rd_mux = mode_q;
            OFS_INT_MASK: rd_mux = mask_q;
            OFS_STATUS: rd_mux = status;
            OFS_RX_HOLD: begin
                rd_mux = {23'h000000, rhr_q};
                rd_err = pwrite;
            end
            default: rd_err = 1'b1;
        endcase
        if (pwrite && (paddr == OFS_INT_MASK || paddr == OFS_STATUS)) begin
            rd_err = 1'b1;
        end
    end

    // Answer one cycle after setup: the access phase ends on its first edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_q <= 1'b0;
            err_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end else if (setup) begin
            ready_q <= 1'b1;
            err_q <= rd_err;
            rdata_q <= pwrite ? 32'h00000000 : rd_mux;
        end else if (done) begin
            ready_q <= 1'b0;
            err_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end
    end

    // --------------------------------------------------------------
    // Mode, control and mask
    // --------------------------------------------------------------
    logic [31:0] ctl;

    assign ctl = wr_to(OFS_CONTROL) ? pwdata : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= MODE_RESET;
        end else if (wr_to(OFS_MODE)) begin
            mode_q <= pwdata & MODE_WRITE_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= MASK_RESET;
        end else begin
            mask_q <= (mask_q
                | (wr_to(OFS_INT_ENABLE) ? (pwdata & EVENT_BITS) : 32'h00000000))
                & ~(wr_to(OFS_INT_DISABLE) ? (pwdata & EVENT_BITS) : 32'h00000000);
        end
    end

    // Disable beats enable when both are written together
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_en_q <= 1'b0;
            tx_en_q <= 1'b0;
        end else begin
            rx_en_q <= ~ctl[CTL_RX_OFF] & (rx_en_q | ctl[CTL_RX_ON]);
            tx_en_q <= ~ctl[CTL_TX_OFF] & (tx_en_q | ctl[CTL_TX_ON]);
        end
    end

    // --------------------------------------------------------------
    // Receive holding and character available
    // --------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rhr_q <= 9'h000;
        end else if (rx_char_done) begin
            rhr_q <= rx_char_data;
        end
    end

    // A character that lands while disabled is held back until enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_pend_q <= 1'b0;
            rx_avail_q <= 1'b0;
        end else begin
            if (ctl[CTL_RX_RESET]) begin
                rx_pend_q <= 1'b0;
            end else if (rx_char_done && !rx_en_q) begin
                rx_pend_q <= 1'b1;
            end else if (rx_en_q) begin
                rx_pend_q <= 1'b0;
            end
            if (ctl[CTL_RX_RESET] || !rx_en_q) begin
                rx_avail_q <= 1'b0;
            end else if (rx_char_done || rx_pend_q) begin
                rx_avail_q <= 1'b1;
            end else if (rd_of(OFS_RX_HOLD)) begin
                rx_avail_q <= 1'b0;
            end
        end
    end

    // --------------------------------------------------------------
    // Transmit holding and break request
    // --------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            thr_full_q <= 1'b0;
            thr_q <= 9'h000;
        end else begin
            if (wr_to(OFS_TX_HOLD)) begin
                thr_full_q <= 1'b1;
                thr_q <= pwdata[8:0];
            end else if (ctl[CTL_TX_RESET] || thr_taken) begin
                thr_full_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brk_pend_q <= 1'b0;
        end else if (ctl[CTL_BREAK_START] && tx_en_q) begin
            brk_pend_q <= 1'b1;
        end else if (ctl[CTL_TX_RESET] || break_started) begin
            brk_pend_q <= 1'b0;
        end
    end

    // --------------------------------------------------------------
    // Smart-card non-acknowledge and repetition count
    // --------------------------------------------------------------
    logic nack_go;
    logic iter_hit;

    always_comb begin
        nack_go = 1'b0;
        iter_hit = 1'b0;
        if (parity_evt && !mode_q[MD_NACK_INHIBIT]) begin
            if (!mode_q[MD_NACK_LIMIT]) begin
                nack_go = 1'b1;
            end else if (iter_cnt_q < max_iter) begin
                nack_go = 1'b1;
            end else begin
                iter_hit = 1'b1;
            end
        end
    end

    // Count restarts on a clean character, so only successive errors add up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            iter_cnt_q <= 3'h0;
            nack_q <= 1'b0;
        end else begin
            nack_q <= nack_go;
            if (!mode_q[MD_NACK_LIMIT] || ctl[CTL_ITER_RESET]) begin
                iter_cnt_q <= 3'h0;
            end else if (nack_go) begin
                iter_cnt_q <= iter_cnt_q + 3'h1;
            end else if (rx_char_done && !parity_evt) begin
                iter_cnt_q <= 3'h0;
            end
        end
    end

    // --------------------------------------------------------------
    // Sticky event flags: a new event wins over its clear
    // --------------------------------------------------------------
    logic [13:0] st_set;
    logic [13:0] st_clr;

    always_comb begin
        st_set = 14'h0000;
        st_clr = 14'h0000;
        st_set[EV_BREAK] = break_evt;
        st_set[EV_OVERRUN] = overrun_evt;
        st_set[EV_FRAMING] = framing_evt;
        st_set[EV_PARITY] = parity_evt;
        st_set[EV_TIMEOUT] = timeout_evt;
        st_set[EV_ITER] = iter_hit;
        st_set[EV_NACK] = nack_evt;
        st_clr[EV_BREAK] = ctl[CTL_STATUS_RESET];
        st_clr[EV_OVERRUN] = ctl[CTL_STATUS_RESET];
        st_clr[EV_FRAMING] = ctl[CTL_STATUS_RESET];
        st_clr[EV_PARITY] = ctl[CTL_STATUS_RESET];
        st_clr[EV_TIMEOUT] = ctl[CTL_TIMEOUT_START];
        st_clr[EV_ITER] = ctl[CTL_ITER_RESET];
        st_clr[EV_NACK] = ctl[CTL_NACK_RESET];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sticky_q <= 14'h0000;
        end else begin
            sticky_q <= (sticky_q & ~st_clr) | st_set;
        end
    end

    // Only flags that the status read returned are cleared by it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            modem_prev_q <= 4'hF;
            modem_chg_q <= 4'h0;
        end else begin
            modem_prev_q <= pin_sync_q[4:1];
            modem_chg_q <= (modem_chg_q
                & ~(rd_of(OFS_STATUS) ? rdata_q[EV_MODEM_LSB +: 4] : 4'h0))
                | (modem_prev_q ^ pin_sync_q[4:1]);
        end
    end

    // --------------------------------------------------------------
    // Status word and interrupt
    // --------------------------------------------------------------
    always_comb begin
        status = 32'h00000000;
        status[13:0] = sticky_q;
        status[EV_RX_AVAIL] = rx_avail_q;
        status[EV_TX_FREE] = tx_en_q & ~thr_full_q & ~brk_pend_q;
        status[EV_RX_END] = rx_xfer_end;
        status[EV_TX_END] = tx_xfer_end;
        status[EV_TX_EMPTY] = tx_en_q & ~thr_full_q & tx_shift_idle;
        status[EV_TXBUF_EMPTY] = tx_buf_empty;
        status[EV_RXBUF_FULL] = rx_buf_full;
        status[EV_MODEM_LSB +: 4] = modem_chg_q;
        status[LVL_MODEM_LSB +: 4] = pin_sync_q[4:1];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & mask_q);
        end
    end

    // --------------------------------------------------------------
    // Channel routing and clock pin
    // --------------------------------------------------------------
    // Registered routing costs a cycle of pin delay but keeps outputs clean
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txd_pin <= 1'b1;
            core_rxd <= 1'b1;
        end else begin
            unique case (umis_loop_t'(loop_mode))
                UMIS_NORMAL: txd_pin <= core_txd;
                UMIS_ECHO: txd_pin <= rx_filt;
                UMIS_LOCAL: txd_pin <= 1'b1;
                UMIS_REMOTE: txd_pin <= rx_line;
            endcase
            unique case (umis_loop_t'(loop_mode))
                UMIS_NORMAL, UMIS_ECHO: core_rxd <= rx_filt;
                UMIS_LOCAL: core_rxd <= core_txd;
                UMIS_REMOTE: core_rxd <= 1'b1;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_out <= 1'b0;
            sck_oe <= 1'b0;
            msb_first <= 1'b0;
            char_bits <= BITS_BASE;
        end else begin
            sck_out <= core_sck;
            sck_oe <= mode_q[MD_CLK_DRIVE]
                & (mode_q[MD_CLK_SRC_LSB +: 2] != CLK_SRC_EXTERNAL);
            msb_first <= mode_q[MD_BIT_ORDER];
            char_bits <= mode_q[MD_NINE_BIT] ? BITS_NINE
                : BITS_BASE + {2'h0, mode_q[MD_CHAR_LEN_LSB +: 2]};
        end
    end

    // --------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------
    assign prdata = rdata_q;
    assign pready = ready_q;
    assign pslverr = err_q;
    assign thr_valid = thr_full_q;
    assign tx_char = thr_q;
    assign break_pending = brk_pend_q;
    assign nack_req = nack_q;
    assign rx_enabled = rx_en_q;
    assign tx_enabled = tx_en_q;
endmodule

// ---- umis_pkg.sv ----
// Constants for the transceiver's mode, event and status logic.
// Assumes a 32-bit APB slave at byte addresses and a single 50 MHz peripheral clock.
// Function
// - Loop field picks normal, echo, local, remote
// - Bit order select: zero LSB first
// - Nine-bit select overrides character length field
// - Drive clock pin unless external clock chosen
// - Nack inhibit suppresses every non-acknowledge
// - Limit off: nack on each parity error
// - Limit on: count, stop nacking, flag
// - Repeat limit field bounds T=0 repetitions
// - Infrared filter: two-of-three vote, sixteenth bit
// - Enable register holds eighteen event bits
// - Disable register mirrors enable bit positions
// - Read-only mask shows enabled events
// - Rx available until holding read/disable
// - Characters during disable raise flag on enable
// - Tx free low: waiting, break, disabled
// - Tx free rises at enable if empty
// - Modem changes flagged, cleared by status read
package umis_pkg;
    // --------------------------------------------------------------
    // Register byte offsets
    // --------------------------------------------------------------
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_MODE = 8'h04;
    localparam logic [7:0] OFS_INT_ENABLE = 8'h08;
    localparam logic [7:0] OFS_INT_DISABLE = 8'h0C;
    localparam logic [7:0] OFS_INT_MASK = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_RX_HOLD = 8'h18;
    localparam logic [7:0] OFS_TX_HOLD = 8'h1C;
    // --------------------------------------------------------------
    // Control register command bits
    // --------------------------------------------------------------
    localparam int CTL_RX_RESET = 2;
    localparam int CTL_TX_RESET = 3;
    localparam int CTL_RX_ON = 4;
    localparam int CTL_RX_OFF = 5;
    localparam int CTL_TX_ON = 6;
    localparam int CTL_TX_OFF = 7;
    localparam int CTL_STATUS_RESET = 8;
    localparam int CTL_BREAK_START = 9;
    localparam int CTL_TIMEOUT_START = 11;
    localparam int CTL_ITER_RESET = 13;
    localparam int CTL_NACK_RESET = 14;
    // --------------------------------------------------------------
    // Mode register fields
    // --------------------------------------------------------------
    localparam int MD_CLK_SRC_LSB = 4;
    localparam int MD_CHAR_LEN_LSB = 6;
    localparam int MD_LOOP_LSB = 14;
    localparam int MD_BIT_ORDER = 16;
    localparam int MD_NINE_BIT = 17;
    localparam int MD_CLK_DRIVE = 18;
    localparam int MD_NACK_INHIBIT = 20;
    localparam int MD_NACK_LIMIT = 21;
    localparam int MD_MAX_ITER_LSB = 24;
    localparam int MD_FILTER = 28;
    localparam logic [31:0] MODE_WRITE_MASK = 32'h173FFFFF;
    localparam logic [31:0] MODE_RESET = 32'h00000000;
    localparam logic [1:0] CLK_SRC_EXTERNAL = 2'h3;
    localparam logic [3:0] BITS_BASE = 4'h5;
    localparam logic [3:0] BITS_NINE = 4'h9;
    // --------------------------------------------------------------
    // Event bit positions, shared by status, enable, disable and mask
    // --------------------------------------------------------------
    localparam int EV_RX_AVAIL = 0;
    localparam int EV_TX_FREE = 1;
    localparam int EV_BREAK = 2;
    localparam int EV_RX_END = 3;
    localparam int EV_TX_END = 4;
    localparam int EV_OVERRUN = 5;
    localparam int EV_FRAMING = 6;
    localparam int EV_PARITY = 7;
    localparam int EV_TIMEOUT = 8;
    localparam int EV_TX_EMPTY = 9;
    localparam int EV_ITER = 10;
    localparam int EV_TXBUF_EMPTY = 11;
    localparam int EV_RXBUF_FULL = 12;
    localparam int EV_NACK = 13;
    localparam int EV_MODEM_LSB = 16;
    localparam int LVL_MODEM_LSB = 20;
    localparam logic [31:0] EVENT_BITS = 32'h000F3FFF;
    localparam logic [31:0] MASK_RESET = 32'h00000000;
    // Channel loop modes
    typedef enum logic [1:0] {
        UMIS_NORMAL = 2'h0,
        UMIS_ECHO = 2'h1,
        UMIS_LOCAL = 2'h2,
        UMIS_REMOTE = 2'h3
    } umis_loop_t;
endpackage

// ---- umis_rx_filter.sv ----
// Two-of-three majority filter on the receive line.
// Assumes the line is already synchronised and sample_tick pulses at 1/16 bit.
`timescale 1ns/1ps
module umis_rx_filter (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic filter_on,
    input wire logic sample_tick,
    // Line
    input wire logic line_in,
    output logic line_out
);
    logic [2:0] samp_q;
    logic vote_q;

    // Idle line is high, so the history starts high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            samp_q <= 3'h7;
        end else if (sample_tick) begin
            samp_q <= {samp_q[1:0], line_in};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vote_q <= 1'b1;
        end else begin
            vote_q <= (samp_q[0] & samp_q[1]) | (samp_q[1] & samp_q[2])
                | (samp_q[0] & samp_q[2]);
        end
    end

    assign line_out = filter_on ? vote_q : line_in;
endmodule

// ---- umis_top_sva.sv ----
// Checker for umis_top: APB answer, mask shadow, option outputs, nack.
// Assumes one pclk domain and the map of umis_pkg.
`timescale 1ns/1ps
module umis_top_sva
    import umis_pkg::*;
(
    // Clock, reset and APB
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [7:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic pready,
    // Options and smart-card line
    input logic parity_evt,
    input logic nack_req,
    input logic msb_first,
    input logic [3:0] char_bits,
    input logic sck_oe
);
    logic [31:0] md_q;
    logic [31:0] msk_q;
    logic wr;
    assign wr = psel && penable && pready && pwrite;
    // Shadows follow completed writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            md_q <= MODE_RESET;
            msk_q <= MASK_RESET;
        end else if (wr) begin
            if (paddr == OFS_MODE) md_q <= pwdata & MODE_WRITE_MASK;
            if (paddr == OFS_INT_ENABLE) msk_q <= msk_q | (pwdata & EVENT_BITS);
            if (paddr == OFS_INT_DISABLE) msk_q <= msk_q & ~pwdata;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    apb_ready_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    mask_read_a: assert property (psel && !penable && !pwrite && paddr == OFS_INT_MASK
        |=> prdata == msk_q) else $error("mask readback wrong");
    bit_order_a: assert property ($stable(md_q) |-> msb_first == md_q[MD_BIT_ORDER])
        else $error("bit order wrong");
    char_len_a: assert property ($stable(md_q) |-> char_bits ==
        (md_q[MD_NINE_BIT] ? BITS_NINE : BITS_BASE + {2'h0, md_q[7:6]}))
        else $error("character length wrong");
    clk_drive_a: assert property ($stable(md_q) |-> sck_oe ==
        (md_q[MD_CLK_DRIVE] && md_q[5:4] != CLK_SRC_EXTERNAL)) else $error("clock pin drive wrong");
    nack_each_a: assert property (parity_evt && $stable(md_q) && md_q[21:20] == 2'h0
        |=> nack_req) else $error("missing nack");
    nack_off_a: assert property ($stable(md_q) && md_q[MD_NACK_INHIBIT] |-> !nack_req)
        else $error("nack while inhibited");
    nack_cause_a: assert property (nack_req |-> $past(parity_evt))
        else $error("nack without parity error");
    cover property (wr && paddr == OFS_INT_ENABLE);
    cover property (nack_req);
    cover property (parity_evt && md_q[MD_NACK_INHIBIT]);
endmodule
bind umis_top umis_top_sva chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .parity_evt(parity_evt), .nack_req(nack_req), .msb_first(msb_first),
    .char_bits(char_bits), .sck_oe(sck_oe));

// ---- umis_remote.sv ----
// Far-side transceiver: drives the receive line and the modem inputs.
// Assumes the bench sets the wanted levels; pins idle high.
`timescale 1ns/1ps
module umis_remote (
    // Clock and levels
    input logic pclk,
    input logic line_lvl,
    input logic [3:0] mdm_lvl,
    // Pins toward the device
    output logic rxd_pin,
    output logic [3:0] mdm_pin
);
    initial begin
        rxd_pin = 1'b1;
        mdm_pin = 4'hF;
    end
    always @(posedge pclk) begin
        rxd_pin <= line_lvl;
        mdm_pin <= mdm_lvl;
    end
endmodule

// ---- tb_umis_top.sv ----
// Bench for umis_top: APB sequences with core events and far-side pins.
// Assumes a 50 MHz pclk and the map of umis_pkg.
`timescale 1ns/1ps
module tb_umis_top;
    import umis_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdat;
    logic pready, pslverr, rerr, txd_pin, core_rxd, sck_oe, nack_req, irq, thr_valid, rxd;
    logic [8:0] tx_char;
    logic [8:0] ev = 9'h000;
    logic [3:0] lv = 4'h0;
    logic [3:0] mdm_lvl = 4'hF;
    logic [3:0] mdm;
    logic line_lvl = 1'b1;
    int n_fail = 0;
    int checked = 0;
    int nk = 0;
    int cyc = 0;
    int i;
    always #10 pclk = ~pclk;
    umis_remote far_u (.pclk(pclk), .line_lvl(line_lvl), .mdm_lvl(mdm_lvl), .rxd_pin(rxd),
        .mdm_pin(mdm));
    umis_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxd_pin(rxd), .txd_pin(txd_pin), .sck_out(), .sck_oe(sck_oe),
        .ri_pin(mdm[0]), .dsr_pin(mdm[1]), .dcd_pin(mdm[2]), .cts_pin(mdm[3]),
        .core_txd(1'b1), .core_sck(1'b0), .sample_tick(1'b1), .core_rxd(core_rxd),
        .rx_char_done(ev[6]), .rx_char_data(9'h0C3), .parity_evt(ev[0]), .framing_evt(ev[1]),
        .overrun_evt(ev[2]), .break_evt(ev[3]), .timeout_evt(ev[4]), .nack_evt(ev[5]),
        .thr_taken(ev[7]), .break_started(ev[8]), .tx_shift_idle(1'b1), .thr_valid(thr_valid),
        .tx_char(tx_char), .break_pending(), .nack_req(nack_req), .msb_first(), .char_bits(),
        .rx_enabled(), .tx_enabled(), .rx_xfer_end(lv[0]), .tx_xfer_end(lv[1]),
        .tx_buf_empty(lv[2]), .rx_buf_full(lv[3]), .irq(irq));
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Hang guard and nack counter
    always @(posedge pclk) begin
        cyc++;
        nk = nk + (nack_req === 1'b1);
        if (cyc > 4000) begin
            n_fail++;
            end_sim();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic ap(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic st;
        ap(1'b0, OFS_STATUS, 32'h0);
    endtask
    task automatic pulse(input logic [8:0] m);
        @(posedge pclk);
        ev <= m;
        @(posedge pclk);
        ev <= 9'h000;
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        ap(1'b0, OFS_INT_MASK, 32'h0);
        chk(rdat, MASK_RESET);
        st();
        chk(rdat & 32'hFFFFFDFF, 32'h00F00000);
        ap(1'b1, OFS_INT_ENABLE, 32'hFFFFFFFF);
        ap(1'b0, OFS_INT_MASK, 32'h0);
        chk(rdat, EVENT_BITS);
        ap(1'b1, OFS_INT_DISABLE, 32'h00050F0F);
        ap(1'b0, OFS_INT_MASK, 32'h0);
        chk(rdat, 32'h000A30F0);
        ap(1'b1, 8'h40, 32'hFFFFFFFF);
        chk(rerr, 32'h1);
        ap(1'b1, OFS_INT_DISABLE, 32'hFFFFFF7F);
        pulse(9'h001);
        repeat (3) @(posedge pclk);
        chk(irq, 32'h1);
        ap(1'b1, OFS_INT_DISABLE, 32'h80);
        repeat (3) @(posedge pclk);
        chk(irq, 32'h0);
        ap(1'b1, OFS_MODE, 32'h00100000);
        pulse(9'h001);
        ap(1'b1, OFS_MODE, 32'h02200000);
        i = nk;
        repeat (3) pulse(9'h001);
        repeat (2) @(posedge pclk);
        chk(32'(nk - i), 32'h2);
        st();
        chk(rdat[EV_ITER], 32'h1);
        ap(1'b1, OFS_CONTROL, 32'h40);
        st();
        chk(rdat[EV_TX_FREE], 32'h1);
        ap(1'b1, OFS_TX_HOLD, 32'h155);
        st();
        chk({rdat[EV_TX_FREE], thr_valid, tx_char}, {2'b01, 9'h155});
        pulse(9'h080);
        ap(1'b1, OFS_CONTROL, 32'h200);
        st();
        chk(rdat[EV_TX_FREE], 32'h0);
        pulse(9'h100);
        ap(1'b1, OFS_CONTROL, 32'h80);
        st();
        chk(rdat[EV_TX_FREE], 32'h0);
        pulse(9'h040);
        st();
        chk(rdat[EV_RX_AVAIL], 32'h0);
        ap(1'b1, OFS_CONTROL, 32'h10);
        st();
        chk(rdat[EV_RX_AVAIL], 32'h1);
        ap(1'b0, OFS_RX_HOLD, 32'h0);
        chk(rdat, 32'h0C3);
        st();
        chk(rdat[EV_RX_AVAIL], 32'h0);
        mdm_lvl <= 4'h6;
        lv <= 4'h9;
        repeat (5) @(posedge pclk);
        st();
        chk({rdat[23:16], rdat[12], rdat[3]}, 10'h1A7);
        st();
        chk(rdat[19:16], 32'h0);
        ap(1'b1, OFS_MODE, 32'h00070080);
        ap(1'b0, OFS_MODE, 32'h0);
        chk({rdat, sck_oe}, {32'h00070080, 1'b1});
        ap(1'b1, OFS_MODE, 32'h00040030);
        repeat (2) @(posedge pclk);
        chk(sck_oe, 32'h0);
        line_lvl <= 1'b0;
        for (i = 0; i < 4; i++) begin
            ap(1'b1, OFS_MODE, (32'(i) << MD_LOOP_LSB) | 32'h10000000);
            repeat (6) @(posedge pclk);
            chk({txd_pin, core_rxd}, 2'(8'h72 >> (2 * i)));
        end
        end_sim();
    end
endmodule
